// ==== logic/itc_pkg.sv ====
// Behaviour
// - scl runs at system clock over (2^n + 72), codes 0..6 give n 5..11
// - outside serial mode, reading bit 0 gives 0 during a soft reset, 1 otherwise
// - bits code 000 means eight data bits, others 1..7; ack adds a clock
// - bit 0 reads 1 after reset, but rate bit 0 as clock select in serial mode
// - mode 00 port, 01 synchronous serial, 10 i2c, 11 reserved
// - writing 10 then 01 to soft reset field starts a monitored reset
package itc_pkg;

  // register byte addresses
  localparam logic [7:0] ADDR_XFER_CTRL_ONE = 8'h04;
  localparam logic [7:0] ADDR_MODE_CTRL_TWO = 8'h10;

  // field positions
  localparam int BITS_LSB = 5;
  localparam int ACK_POS = 4;
  localparam int RATE_LSB = 0;
  localparam int MODE_LSB = 2;
  localparam int SRST_LSB = 0;

  // reset values
  localparam logic [2:0] RST_BITS = 3'h0;
  localparam logic RST_ACK = 1'b0;
  localparam logic [2:0] RST_RATE = 3'h0;

  // scl divider figures
  localparam logic [2:0] RATE_RESERVED = 3'h7;
  localparam logic [3:0] RATE_BASE_EXP = 4'h5;
  localparam logic [11:0] DIV_OFFSET = 12'h048;

  // soft reset command codes and duration in clock cycles
  localparam logic [1:0] SRST_ARM = 2'h2;
  localparam logic [1:0] SRST_FIRE = 2'h1;
  localparam int SOFT_RESET_CYCLES = 4;

  typedef enum logic [1:0] {
    MODE_PORT = 2'b00,
    MODE_SYNC_SERIAL = 2'b01,
    MODE_I2C = 2'b10,
    MODE_RESERVED = 2'b11
  } itc_mode_t;

  typedef enum logic [1:0] {
    SR_IDLE = 2'b00,
    SR_ARMED = 2'b01,
    SR_BUSY = 2'b10
  } itc_srst_t;

  typedef struct packed {
    itc_mode_t mode;
    logic [2:0] bits;
    logic ack;
    logic [2:0] rate;
    logic [3:0] clocks;
  } itc_cfg_t;

endpackage : itc_pkg

// ==== logic/itc_transfer_control.sv ====
// Added by the designer: the register addresses and strobed register access.
`timescale 1ns/10ps
module itc_transfer_control #(
  parameter int SRST_LEN = itc_pkg::SOFT_RESET_CYCLES
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  output itc_pkg::itc_cfg_t o_cfg,
  output logic o_soft_busy,
  output logic o_scl_o,
  output logic o_scl_oe_n
);

  // scl period in system clocks for a rate code
  function automatic logic [11:0] itc_period(input logic [2:0] rate);
    logic [3:0] expo;
    expo = {1'b0, rate} + itc_pkg::RATE_BASE_EXP;
    itc_period = (12'h001 << expo) + itc_pkg::DIV_OFFSET;
  endfunction : itc_period

  // clocks per transfer from bits code and ack enable
  function automatic logic [3:0] itc_clocks(input logic [2:0] bits,
                                            input logic ack);
    logic [3:0] len;
    len = (bits == 3'h0) ? 4'h8 : {1'b0, bits};
    itc_clocks = len + {3'h0, ack};
  endfunction : itc_clocks

  logic [2:0] bits_r;
  logic ack_r;
  logic [2:0] rate_r;
  itc_pkg::itc_mode_t mode_r;
  itc_pkg::itc_srst_t state_r;
  itc_pkg::itc_srst_t state_nxt;
  logic [7:0] srst_cnt_r;
  logic [7:0] srst_cnt_nxt;
  logic busy_r;
  logic [11:0] div_cnt_r;
  logic [11:0] div_nxt;
  logic scl_oe_n_r;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  itc_pkg::itc_cfg_t cfg_r;
  itc_pkg::itc_cfg_t cfg_nxt;

  // address decode
  wire logic wr_one = i_wr && (i_addr == itc_pkg::ADDR_XFER_CTRL_ONE);
  wire logic wr_two = i_wr && (i_addr == itc_pkg::ADDR_MODE_CTRL_TWO);
  wire logic rd_one = i_rd && (i_addr == itc_pkg::ADDR_XFER_CTRL_ONE);
  wire logic rd_two = i_rd && (i_addr == itc_pkg::ADDR_MODE_CTRL_TWO);
  wire logic [1:0] srst_field = i_wdata[itc_pkg::SRST_LSB +: 2];
  wire logic in_busy = (state_r == itc_pkg::SR_BUSY);
  wire logic srst_done = (srst_cnt_r == 8'(SRST_LEN - 1));

  // soft reset sequencer: arm, fire, then hold busy for SRST_LEN cycles
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      itc_pkg::SR_IDLE: begin
        if (wr_two && srst_field == itc_pkg::SRST_ARM) begin
          state_nxt = itc_pkg::SR_ARMED;
        end
      end
      itc_pkg::SR_ARMED: begin
        if (wr_two && srst_field == itc_pkg::SRST_FIRE) begin
          state_nxt = itc_pkg::SR_BUSY;
        end else if (wr_two && srst_field != itc_pkg::SRST_ARM) begin
          state_nxt = itc_pkg::SR_IDLE;
        end
      end
      itc_pkg::SR_BUSY: begin
        // commands during the reset are ignored, no retrigger
        if (srst_done) begin
          state_nxt = itc_pkg::SR_IDLE;
        end
      end
      default: begin
        state_nxt = itc_pkg::SR_IDLE;
      end
    endcase
  end

  // cycle count inside the busy window
  assign srst_cnt_nxt = in_busy ? srst_cnt_r + 8'h01 : 8'h00;

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      state_r <= itc_pkg::SR_IDLE;
      srst_cnt_r <= 8'h00;
      busy_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      srst_cnt_r <= srst_cnt_nxt;
      busy_r <= (state_nxt == itc_pkg::SR_BUSY);
    end
  end

  // configuration fields; only documented bits are stored
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      bits_r <= itc_pkg::RST_BITS;
      ack_r <= itc_pkg::RST_ACK;
      rate_r <= itc_pkg::RST_RATE;
    end else if (wr_one) begin
      bits_r <= i_wdata[itc_pkg::BITS_LSB +: 3];
      ack_r <= i_wdata[itc_pkg::ACK_POS];
      rate_r <= i_wdata[itc_pkg::RATE_LSB +: 3];
    end
  end

  // mode field; reserved code is stored but drives nothing
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      mode_r <= itc_pkg::MODE_PORT;
    end else if (wr_two) begin
      mode_r <= itc_pkg::itc_mode_t'(i_wdata[itc_pkg::MODE_LSB +: 2]);
    end
  end

  // scl divider, runs only in i2c mode with a legal rate
  wire logic [11:0] period_w = itc_period(rate_r);
  wire logic [11:0] half_w = {1'b0, period_w[11:1]};
  wire logic run_w = (mode_r == itc_pkg::MODE_I2C) &&
                     (rate_r != itc_pkg::RATE_RESERVED) && !in_busy;
  wire logic wrap_w = (div_cnt_r == period_w - 12'h001);
  assign div_nxt = (!run_w || wrap_w) ? 12'h000 : div_cnt_r + 12'h001;

  // low half first so a restart from stop begins on a clean low phase
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      div_cnt_r <= 12'h000;
      scl_oe_n_r <= 1'b1;
    end else begin
      div_cnt_r <= div_nxt;
      scl_oe_n_r <= !(run_w && div_cnt_r < half_w);
    end
  end

  // configuration handed to the transfer logic
  always_comb begin
    cfg_nxt.mode = mode_r;
    cfg_nxt.bits = bits_r;
    cfg_nxt.ack = ack_r;
    cfg_nxt.rate = rate_r;
    cfg_nxt.clocks = itc_clocks(bits_r, ack_r);
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      cfg_r <= '0;
    end else begin
      cfg_r <= cfg_nxt;
    end
  end

  // bit 0 is the reset monitor except as clock select in serial mode
  wire logic bit0_w = (mode_r == itc_pkg::MODE_SYNC_SERIAL) ?
                      rate_r[0] : !in_busy;
  wire logic [31:0] rd_one_w = {24'h000000, bits_r, ack_r, 1'b1,
                                2'b00, bit0_w};
  wire logic [31:0] rd_two_w = {28'h0000000, mode_r, 2'b00};

  // read data stand for one cycle only; unmapped reads give zero
  always_comb begin
    rdata_nxt = 32'h00000000;
    if (rd_one) begin
      rdata_nxt = rd_one_w;
    end else if (rd_two) begin
      rdata_nxt = rd_two_w;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      rdata_r <= 32'h00000000;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign o_rdata = rdata_r;
  assign o_cfg = cfg_r;
  assign o_soft_busy = busy_r;
  assign o_scl_o = 1'b0; // open drain, only the enable moves
  assign o_scl_oe_n = scl_oe_n_r;

  // checks
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  sequence seq_arm_write;
    wr_two && srst_field == itc_pkg::SRST_ARM && !in_busy;
  endsequence

  sequence seq_fire_write;
    wr_two && srst_field == itc_pkg::SRST_FIRE;
  endsequence

  sequence seq_busy_window;
    o_soft_busy [*4] ##1 !o_soft_busy;
  endsequence

  // software leaves exactly one idle cycle between arm and fire
  sequence seq_cmd_gap;
    !wr_two;
  endsequence

  chk_soft_reset_run: assert property (
    seq_arm_write ##1 seq_cmd_gap ##1 seq_fire_write |=> seq_busy_window)
    else $error("soft reset busy window wrong");

  chk_monitor_read_bit: assert property (
    rd_one && mode_r != itc_pkg::MODE_SYNC_SERIAL
    |=> o_rdata[0] == !$past(o_soft_busy))
    else $error("reset monitor bit wrong");

  chk_scl_wrap_count: assert property (
    run_w && div_cnt_r == itc_period(rate_r) - 12'h001
    |=> div_cnt_r == 12'h000)
    else $error("scl divider did not wrap");

  chk_scl_step_count: assert property (
    run_w && !wrap_w |=> div_cnt_r == $past(div_cnt_r) + 12'h001)
    else $error("scl divider did not step");

  chk_port_scl_idle: assert property (
    mode_r != itc_pkg::MODE_I2C |=> o_scl_oe_n)
    else $error("scl driven outside i2c mode");

  chk_clocks_nine_ack: assert property (
    bits_r == 3'h0 && ack_r |=> o_cfg.clocks == 4'h9)
    else $error("eight bits with ack not nine clocks");

  chk_clocks_short_len: assert property (
    bits_r != 3'h0 && !ack_r |=> o_cfg.clocks == {1'b0, $past(bits_r)})
    else $error("short transfer clock count wrong");

  chk_reset_field_values: assert property (
    $past(i_rst) |-> bits_r == 3'h0 && rate_r == 3'h0 &&
    mode_r == itc_pkg::MODE_PORT && !o_soft_busy)
    else $error("reset values wrong");

  chk_reserved_bits_read: assert property (
    rd_one |=> o_rdata[31:8] == 24'h000000 && o_rdata[3])
    else $error("reserved bits read wrong");

  // busy window length and what it does to the clock wire
  chk_busy_len_exact: assert property (
    $fell(o_soft_busy) |-> $past(o_soft_busy, 4) && !$past(o_soft_busy, 5))
    else $error("busy window length wrong");

  chk_busy_scl_release: assert property (
    o_soft_busy |=> o_scl_oe_n)
    else $error("scl pulled during soft reset");

  chk_busy_cmd_ignored: assert property (
    in_busy && wr_two |=> state_r != itc_pkg::SR_ARMED)
    else $error("command taken during soft reset");

  chk_fire_needs_arm: assert property (
    state_r == itc_pkg::SR_IDLE |=> !o_soft_busy)
    else $error("soft reset fired without arming");

  // scl phases; low half first within each period
  chk_scl_low_half: assert property (
    run_w && div_cnt_r < half_w |=> !o_scl_oe_n)
    else $error("scl not low in first half");

  chk_scl_high_half: assert property (
    run_w && div_cnt_r >= half_w |=> o_scl_oe_n)
    else $error("scl not released in second half");

  chk_reserved_rate_idle: assert property (
    rate_r == itc_pkg::RATE_RESERVED |=> o_scl_oe_n)
    else $error("scl running on reserved rate");

  // register writes land in the fields they name
  chk_rate_write_store: assert property (
    wr_one |=> rate_r == $past(i_wdata[itc_pkg::RATE_LSB +: 3]))
    else $error("rate field not stored");

  chk_bits_write_store: assert property (
    wr_one |=> bits_r == $past(i_wdata[itc_pkg::BITS_LSB +: 3]) &&
    ack_r == $past(i_wdata[itc_pkg::ACK_POS]))
    else $error("bits or ack field not stored");

  chk_mode_write_store: assert property (
    wr_two |=> mode_r == $past(i_wdata[itc_pkg::MODE_LSB +: 2]))
    else $error("mode field not stored");

  // read side: serial mode bit 0, idle bus gives zero
  chk_serial_bit0_read: assert property (
    rd_one && mode_r == itc_pkg::MODE_SYNC_SERIAL
    |=> o_rdata[0] == $past(rate_r[0]))
    else $error("serial mode bit 0 not clock select");

  chk_rdata_idle_zero: assert property (
    !rd_one && !rd_two |=> o_rdata == 32'h00000000)
    else $error("read data not cleared");

  // configuration copy trails the fields by exactly one cycle
  chk_cfg_mirror: assert property (
    o_cfg.bits == $past(bits_r) && o_cfg.ack == $past(ack_r) &&
    o_cfg.rate == $past(rate_r) && o_cfg.mode == $past(mode_r))
    else $error("configuration copy lags wrong");

endmodule : itc_transfer_control

// ==== testbench/itc_bus_peer.sv ====
`timescale 1ns/10ps
// far side of the clock wire: open drain with a pull-up
module itc_bus_peer (
  input wire logic i_scl_o,
  input wire logic i_scl_oe_n,
  output logic o_scl_line
);
  // a released wire floats high; no device here stretches it
  assign o_scl_line = (!i_scl_oe_n) ? i_scl_o : 1'b1;
endmodule : itc_bus_peer

// ==== testbench/itc_transfer_control_tb_top.sv ====
`timescale 1ns/10ps
module itc_transfer_control_tb_top;
  localparam logic [7:0] A1 = itc_pkg::ADDR_XFER_CTRL_ONE;
  localparam logic [7:0] A2 = itc_pkg::ADDR_MODE_CTRL_TWO;
  logic i_clock = 1'b0;
  logic i_rst = 1'b1;
  logic [7:0] i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [31:0] o_rdata;
  itc_pkg::itc_cfg_t o_cfg;
  logic o_soft_busy;
  logic o_scl_o;
  logic o_scl_oe_n;
  logic scl_line;
  logic [31:0] rv;
  int mismatches = 0;
  int checked = 0;

  // 100 MHz system clock
  always #5 i_clock = ~i_clock;

  itc_transfer_control #(.SRST_LEN(4)) dut (
    .i_clock(i_clock), .i_rst(i_rst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_cfg(o_cfg), .o_soft_busy(o_soft_busy), .o_scl_o(o_scl_o),
    .o_scl_oe_n(o_scl_oe_n)
  );
  itc_bus_peer peer (
    .i_scl_o(o_scl_o), .i_scl_oe_n(o_scl_oe_n), .o_scl_line(scl_line)
  );

  task automatic check(input string name, input logic [31:0] got, exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  // one-cycle strobes, changed just after the edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clock);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clock);
    i_wr <= 1'b0;
  endtask : wr

  // data stand only in the cycle after the read edge
  task automatic rd(input logic [7:0] a);
    @(posedge i_clock);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clock);
    i_rd <= 1'b0;
    #1 rv = o_rdata;
  endtask : rd

  // edges while the wire stays at lvl, capped so a stuck wire ends
  task automatic span(input logic lvl, output int n);
    n = 0;
    #1;
    while (scl_line === lvl && n < 3000) begin
      @(posedge i_clock);
      #1 n++;
    end
  endtask : span

  task automatic test_reset;
    #1 check("scl idle", 32'(scl_line), 32'h1);
    rd(A1);
    check("ctrl_one", rv, 32'h0000_0009);
    rd(A2);
    check("mode_two", rv, 32'h0);
    rd(8'h20);
    check("unmapped", rv, 32'h0);
  endtask : test_reset

  // every length code, ack set for even codes; reserved bits 31..8 written as ones
  task automatic test_bits;
    logic [2:0] b;
    for (int i = 0; i < 8; i++) begin
      b = 3'(i);
      wr(A1, 32'hFFFF_FF00 | {b, !b[0], 4'h0});
      rd(A1);
      check("ctrl_one", rv, {24'h0, b, !b[0], 4'h9});
      check("clocks", 32'(o_cfg.clocks), 32'(i == 0 ? 8 : i) + !b[0]);
      check("cfg bits", 32'(o_cfg.bits), 32'(b));
      check("cfg ack", 32'(o_cfg.ack), 32'(!b[0]));
    end
  endtask : test_bits

  // stop, set rate, restart, so the first period is a whole one
  task automatic test_scl;
    int lo;
    int hi;
    int p;
    for (int r = 0; r < 7; r++) begin
      p = (1 << (r + 5)) + 72;
      wr(A2, 32'h0);
      wr(A1, 32'(r));
      wr(A2, 32'h8);
      span(1'b1, lo);
      span(1'b0, lo);
      span(1'b1, hi);
      check("scl low", 32'(lo), 32'(p / 2));
      check("scl period", 32'(lo + hi), 32'(p));
      check("cfg rate", 32'(o_cfg.rate), 32'(r));
    end
    // stop first so a low phase in flight cannot reach the span
    wr(A2, 32'h0);
    wr(A1, 32'h7);
    wr(A2, 32'h8);
    span(1'b1, hi);
    check("reserved rate", 32'(hi), 32'd3000);
    wr(A2, 32'h0);
    wr(A1, 32'h0);
    for (int m = 0; m < 4; m += 1 + (m == 1)) begin
      wr(A2, 32'(m << 2));
      span(1'b1, hi);
      check("no scl", 32'(hi), 32'd3000);
    end
  endtask : test_scl

  task automatic test_srst;
    int n;
    int lo;
    wr(A2, 32'h8);
    wr(A2, 32'hA);
    wr(A2, 32'h9);
    // scl release lags busy by one registered cycle, so lo starts late
    #1 n = o_soft_busy;
    lo = 0;
    repeat (11) begin
      @(posedge i_clock);
      #1 n += o_soft_busy;
      lo += o_soft_busy & !scl_line;
    end
    check("busy len", 32'(n), 32'd4);
    check("scl held", 32'(lo), 32'h0);
    wr(A2, 32'h9);
    wr(A2, 32'hA);
    repeat (6) @(posedge i_clock);
    #1 check("wrong order", 32'(o_soft_busy), 32'h0);
    wr(A2, 32'hA);
    wr(A2, 32'h9);
    wr(A2, 32'hA); // arm written while busy must be dropped
    rd(A1);
    check("monitor busy", 32'(rv[0]), 32'h0);
    repeat (10) @(posedge i_clock);
    rd(A1);
    check("monitor idle", 32'(rv[0]), 32'h1);
    wr(A2, 32'h9);
    #1 check("ignored arm", 32'(o_soft_busy), 32'h0);
  endtask : test_srst

  // length field already cleared before entering serial mode
  task automatic test_serial;
    wr(A1, 32'h0);
    wr(A2, 32'h4);
    rd(A1);
    check("rate bit0", rv, 32'h0000_0008);
    rd(A2);
    check("mode", rv, 32'h4);
    check("cfg mode", 32'(o_cfg.mode), 32'h1);
  endtask : test_serial

  task automatic print_verdict;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : print_verdict

  // whole run needs roughly 17000 cycles
  initial begin
    repeat (60000) @(posedge i_clock);
    mismatches++;
    print_verdict();
  end

  initial begin
    repeat (12) @(posedge i_clock);
    i_rst <= 1'b0;
    test_reset();
    test_bits();
    test_scl();
    test_srst();
    test_serial();
    print_verdict();
  end
endmodule : itc_transfer_control_tb_top
